// *** verilog/eeprom_dac_core.sv ***
`timescale 1ns/1ps
// Notes on behaviour
// - first select fall restores word 0 to dacs
// - clock and data ignored, output silent during restore
// - restore runs once per reset only
// - frame is opcode, address, two data bytes
// - read, write, recall opcodes with address
// - unlock and lock opcodes, unlock before writing
// - sleep enter and exit opcodes switch mode
// - thirty-second rising edge starts self-timed write
// - output low while busy, high when done
// - ready level held until select high or start
// - read data from seventeenth falling edge, msb first
// - continued clocking reads next word, wrapping
// - starts locked, locked writes leave memory unchanged
// - reads ignore lock state
// - wake restores codes held before sleep
// - recall loads high byte ch0, low ch1
// - recall ignored while sleeping
// - sample on rising, read data changes on falling
// - start asleep, restore sets normal mode
// - word 0 write in normal mode updates dacs
// - output undriven except read data or ready/busy
module eeprom_dac_core
   import eeprom_dac_pkg::*;
#(
   parameter int unsigned PROGRAM_CYCLES_P = PROGRAM_CYCLES
) (
   input wire logic clock_in,
   input wire logic rst_in,
   input wire logic select_n_in,
   input wire logic serial_clock_in,
   input wire logic serial_in_in,
   output logic serial_out_out,
   output logic serial_out_oe_n_out,
   output logic [7:0] analog_out_0_out,
   output logic [7:0] analog_out_1_out,
   output logic analog_enable_out
);
   // ----------------------------------------
   // types and state
   // ----------------------------------------
   // one state per phase of the port; the first three only run once
   // after each reset, which is what keeps the restore to a single pass
   typedef enum logic [2:0] {
      ST_POWERUP,
      ST_RESTORE,
      ST_FIRST_LOW,
      ST_IDLE,
      ST_FRAME,
      ST_BUSY,
      ST_READY
   } core_state_t;

   // all state in one record; the next-state copy starts as a copy of
   // this, so any field a branch leaves alone simply holds its value
   // and no latch can form in the combinational block
   typedef struct packed {
      core_state_t st;
      logic [5:0] bits;
      logic [31:0] shift;
      logic [6:0] addr;
      logic rd_mode;
      logic [3:0] rd_idx;
      logic unlocked;
      logic normal;
      logic [7:0] code0;
      logic [7:0] code1;
      logic [TIMER_BITS-1:0] timer;
      logic [3:0] settle;
      logic dout;
      logic dout_oe_n;
      logic we;
      logic [15:0] wdata;
   } core_t;

   // power application: asleep, locked, output line released and the
   // store address parked on word 0 ready for the restore
   localparam core_t CORE_RESET = '{
      st: ST_POWERUP,
      bits: 6'h00,
      shift: 32'h0000_0000,
      addr: WORD0_ADDR,
      rd_mode: 1'b0,
      rd_idx: READ_FIRST_BIT,
      unlocked: 1'b0,
      normal: 1'b0,
      code0: DAC_CODE_RESET,
      code1: DAC_CODE_RESET,
      timer: '0,
      settle: 4'h0,
      dout: 1'b0,
      dout_oe_n: 1'b1,
      we: 1'b0,
      wdata: 16'h0000
   };

   // the program timer counts system clocks; the default is the full
   // program time, and simulation shortens it through the parameter.
   // the cast is safe while the cycle count fits in the timer width
   localparam logic [TIMER_BITS-1:0] PROGRAM_LAST = TIMER_BITS'(PROGRAM_CYCLES_P - 1);

   // nxt_shift and op_now are views of the shifter with the incoming bit
   // already in, so a command can act on the same edge its last bit lands
   core_t q;
   core_t n;
   logic [31:0] nxt_shift;
   logic [7:0] op_now;

   // the pin events and the store port travel in interfaces so the
   // helpers stay small and their signals cannot be crossed by hand
   pin_event_if ev ();
   word_port_if mem ();

   // ----------------------------------------
   // submodules
   // ----------------------------------------
   // every pin passes two flops here before any decision reads it; the
   // cost is about three clocks of lag, harmless while each serial clock
   // half period lasts at least four system clocks
   pin_sync u_pin_sync (
      .clock_in(clock_in),
      .rst_in(rst_in),
      .select_n_in(select_n_in),
      .serial_clock_in(serial_clock_in),
      .serial_in_in(serial_in_in),
      .ev(ev)
   );

   // the store reads through a register, so new data shows two clocks
   // after the address moves; every user below waits at least that long
   word_store u_word_store (
      .clock_in(clock_in),
      .port(mem)
   );

   // store port runs straight from registers
   assign mem.addr = q.addr;
   assign mem.we = q.we;
   assign mem.wdata = q.wdata;

   // ----------------------------------------
   // next state
   // ----------------------------------------
   // single combinational block for the whole port; every path starts
   // from the held state, clears the write strobe and then overrides
   // only what that state needs
   always_comb begin
      n = q;
      n.we = 1'b0;
      nxt_shift = {q.shift[30:0], ev.din};
      op_now = nxt_shift[31:24];
      case (q.st)
         // wait for the first select fall after reset
         ST_POWERUP: begin
            if (ev.sel_fall) begin
               n.st = ST_RESTORE;
               n.addr = WORD0_ADDR;
               n.settle = 4'h0;
            end
         end

         // word 0 is read out; serial pins are not looked at here
         // settle covers the two-clock store latency with margin, far
         // inside the restore time limit
         ST_RESTORE: begin
            n.settle = q.settle + 4'h1;
            if (q.settle == RESTORE_SETTLE_CYCLES) begin
               n.code0 = mem.rdata[15:8];
               n.code1 = mem.rdata[7:0];
               n.normal = 1'b1;
               n.st = ST_FIRST_LOW;
            end
         end

         // rest of the first low period accepts no instruction
         ST_FIRST_LOW: begin
            if (ev.sel_n) begin
               n.st = ST_IDLE;
            end
         end

         // select fall opens a fresh frame
         ST_IDLE: begin
            n.dout_oe_n = 1'b1;
            if (ev.sel_fall) begin
               n.st = ST_FRAME;
               n.bits = 6'h00;
               n.shift = 32'h0000_0000;
               n.rd_mode = 1'b0;
            end
         end

         // shift in header and data, or shift out read data after the
         // header; select rising at any point drops back to idle
         ST_FRAME: begin
            if (ev.sel_n) begin
               // partial frame dropped with no effect
               n.st = ST_IDLE;
               n.rd_mode = 1'b0;
               n.dout_oe_n = 1'b1;
            end else if (q.rd_mode) begin
               // read data changes only on falling clock edges
               // the store address moves after bit 0 so the next word is ready
               if (ev.sk_fall) begin
                  n.dout = mem.rdata[q.rd_idx];
                  n.dout_oe_n = 1'b0;
                  n.rd_idx = q.rd_idx - 4'h1;
                  if (q.rd_idx == 4'h0) begin
                     n.addr = q.addr + 7'h01;
                  end
               end
            end else if (ev.sk_rise && q.bits != FRAME_BITS) begin
               n.shift = nxt_shift;
               n.bits = q.bits + 6'h01;
               if (q.bits == HEADER_LAST_BIT) begin
                  // address byte: upper seven bits, trailing zero dropped
                  // a read opcode switches the frame to output from here on
                  n.addr = nxt_shift[7:1];
                  if (nxt_shift[15:8] == OP_READ) begin
                     n.rd_mode = 1'b1;
                     n.rd_idx = READ_FIRST_BIT;
                  end
               end
               if (q.bits == FRAME_LAST_BIT) begin
                  case (op_now)
                     OP_WRITE: begin
                        // dacs follow word 0 even when locked
                        if (q.normal && q.addr == WORD0_ADDR) begin
                           n.code0 = nxt_shift[15:8];
                           n.code1 = nxt_shift[7:0];
                        end
                        if (q.unlocked) begin
                           n.we = 1'b1;
                           n.wdata = nxt_shift[15:0];
                           n.st = ST_BUSY;
                           n.timer = '0;
                           n.dout = 1'b0;
                           n.dout_oe_n = 1'b0;
                        end
                     end

                     // lock state only changes on a complete frame
                     OP_UNLOCK: begin
                        n.unlocked = 1'b1;
                     end

                     OP_LOCK: begin
                        n.unlocked = 1'b0;
                     end

                     // codes are kept so a later wake can show them again
                     OP_SLEEP_ENTER: begin
                        n.normal = 1'b0;
                     end

                     OP_SLEEP_EXIT: begin
                        // codes were never touched while asleep
                        n.normal = 1'b1;
                     end

                     OP_RECALL: begin
                        // rdata holds the word addressed at bit 16
                        if (q.normal) begin
                           n.code0 = mem.rdata[15:8];
                           n.code1 = mem.rdata[7:0];
                        end
                     end

                     default: begin
                        // factory test and unknown opcodes do nothing
                        n.bits = FRAME_BITS;
                     end
                  endcase
               end
            end
         end

         // self-timed write: low only while select is low
         // the store was already written on entry; the timer only models
         // how long the cells stay busy
         ST_BUSY: begin
            n.timer = q.timer + TIMER_BITS'(1);
            n.dout = 1'b0;
            n.dout_oe_n = ev.sel_n;
            if (q.timer == PROGRAM_LAST) begin
               n.dout = 1'b1;
               if (ev.sel_n) begin
                  n.st = ST_IDLE;
               end else begin
                  n.st = ST_READY;
               end
            end
         end

         // ready level held until select rises or a start bit comes
         // any opcode starts with a 1, so that bit is the first frame bit
         ST_READY: begin
            n.dout = 1'b1;
            if (ev.sel_n) begin
               n.dout_oe_n = 1'b1;
               n.st = ST_IDLE;
            end else if (ev.sk_rise && ev.din) begin
               n.dout_oe_n = 1'b1;
               n.st = ST_FRAME;
               n.shift = {31'h0000_0000, 1'b1};
               n.bits = 6'h01;
               n.rd_mode = 1'b0;
            end
         end

         // unused encodings recover to idle
         default: begin
            n.st = ST_IDLE;
         end
      endcase
   end

   // ----------------------------------------
   // state register
   // ----------------------------------------
   // synchronous reset stands for power application; the store is
   // outside this record and keeps its contents across it
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         q <= CORE_RESET;
      end else begin
         q <= n;
      end
   end

   // ----------------------------------------
   // outputs, all from flip-flops
   // ----------------------------------------
   // nothing is decoded on the way out, so the pins never glitch
   // when several fields change on one clock
   assign serial_out_out = q.dout;
   assign serial_out_oe_n_out = q.dout_oe_n;
   assign analog_out_0_out = q.code0;
   assign analog_out_1_out = q.code1;
   assign analog_enable_out = q.normal;
endmodule : eeprom_dac_core

// *** verilog/eeprom_dac_pkg.sv ***
// ----------------------------------------
// shared constants for the serial memory with two dac channels
// ----------------------------------------
package eeprom_dac_pkg;
   localparam int WORD_BITS = 16;
   localparam int ADDR_BITS = 7;
   localparam int DEPTH = 128;
   localparam int CODE_BITS = 8;

   // opcodes, first byte of every frame, msb first
   localparam logic [7:0] OP_READ = 8'ha8;
   localparam logic [7:0] OP_WRITE = 8'ha4;
   localparam logic [7:0] OP_RECALL = 8'ha2;
   localparam logic [7:0] OP_UNLOCK = 8'ha3;
   localparam logic [7:0] OP_LOCK = 8'ha0;
   localparam logic [7:0] OP_SLEEP_ENTER = 8'hac;
   localparam logic [7:0] OP_SLEEP_EXIT = 8'ha6;
   localparam logic [7:0] OP_FACTORY_TEST = 8'haf;

   // bit counts inside a frame
   localparam logic [5:0] HEADER_LAST_BIT = 6'h0f;
   localparam logic [5:0] FRAME_LAST_BIT = 6'h1f;
   localparam logic [5:0] FRAME_BITS = 6'h20;
   localparam logic [3:0] READ_FIRST_BIT = 4'hf;
   localparam logic [6:0] WORD0_ADDR = 7'h00;

   // values after reset
   localparam logic [7:0] DAC_CODE_RESET = 8'h00;
   localparam logic [2:0] SYNC_SEL_RESET = 3'h7;
   localparam logic [2:0] SYNC_SK_RESET = 3'h7;

   // timing at 100 mhz
   localparam int CLOCK_MHZ = 100;
   localparam int PROGRAM_TIME_MS = 10;
   localparam int PROGRAM_CYCLES = PROGRAM_TIME_MS * 1000 * CLOCK_MHZ;
   localparam int RESTORE_TIME_US = 2000;
   localparam int RESTORE_MAX_CYCLES = RESTORE_TIME_US * CLOCK_MHZ;
   localparam logic [3:0] RESTORE_SETTLE_CYCLES = 4'h3;
   localparam int TIMER_BITS = 24;
endpackage : eeprom_dac_pkg

// *** verilog/eeprom_dac_if.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// synchronised pin events
// ----------------------------------------
interface pin_event_if;
   logic sel_n;
   logic din;
   logic sk_rise;
   logic sk_fall;
   logic sel_fall;
   modport sync (output sel_n, output din, output sk_rise, output sk_fall, output sel_fall);
   modport core (input sel_n, input din, input sk_rise, input sk_fall, input sel_fall);
endinterface : pin_event_if

// ----------------------------------------
// word store port
// ----------------------------------------
interface word_port_if;
   logic [6:0] addr;
   logic we;
   logic [15:0] wdata;
   logic [15:0] rdata;
   modport ctrl (output addr, output we, output wdata, input rdata);
   modport store (input addr, input we, input wdata, output rdata);
endinterface : word_port_if

// *** verilog/pin_sync.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// pin synchronisers and edge finders
// ----------------------------------------
module pin_sync
   import eeprom_dac_pkg::*;
(
   input wire logic clock_in,
   input wire logic rst_in,
   input wire logic select_n_in,
   input wire logic serial_clock_in,
   input wire logic serial_in_in,
   pin_event_if.sync ev
);
   typedef struct packed {
      logic [2:0] sk;
      logic [2:0] sel;
      logic [1:0] din;
   } sync_t;

   sync_t q;
   sync_t n;

   // bit 0 is the metastable stage; edges look only at stages 1 and 2
   always_comb begin
      n.sk = {q.sk[1:0], serial_clock_in};
      n.sel = {q.sel[1:0], select_n_in};
      n.din = {q.din[0], serial_in_in};
   end

   // select resets high so a pin held low at power-up shows as a fall
   // clock resets high like the idle host clock, so no false edge follows reset
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         q <= '{sk: SYNC_SK_RESET, sel: SYNC_SEL_RESET, din: 2'h0};
      end else begin
         q <= n;
      end
   end

   // din stage 1 has the same age as sk stage 1
   assign ev.sel_n = q.sel[1];
   assign ev.din = q.din[1];
   assign ev.sk_rise = q.sk[1] & ~q.sk[2];
   assign ev.sk_fall = ~q.sk[1] & q.sk[2];
   assign ev.sel_fall = ~q.sel[1] & q.sel[2];
endmodule : pin_sync

// *** verilog/word_store.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// 128 x 16 nonvolatile word array
// ----------------------------------------
module word_store
   import eeprom_dac_pkg::*;
(
   input wire logic clock_in,
   word_port_if.store port
);
   typedef struct packed {
      logic [15:0] rdata;
   } store_t;

   logic [WORD_BITS-1:0] mem [DEPTH];
   store_t q;
   store_t n;

   always_comb begin
      n.rdata = mem[port.addr];
   end

   // no reset: contents survive power cycles, like the real cells
   always_ff @(posedge clock_in) begin
      q <= n;
      if (port.we) begin
         mem[port.addr] <= port.wdata;
      end
   end

   assign port.rdata = q.rdata;
endmodule : word_store

// *** verif/port_check_properties.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// port checker
// ----------------------------------------
module port_check
   import eeprom_dac_pkg::*;
#(
   parameter int unsigned PROGRAM_CYCLES_P = PROGRAM_CYCLES
) (
   input wire logic clock_in,
   input wire logic rst_in,
   input wire logic select_n_in,
   input wire logic serial_clock_in,
   input wire logic serial_in_in,
   input wire logic serial_out_out,
   input wire logic serial_out_oe_n_out,
   input wire logic [7:0] analog_out_0_out,
   input wire logic [7:0] analog_out_1_out,
   input wire logic analog_enable_out
);
   logic armed_ff, first_ff, woke_ff, sk_ff, cs_ff;
   logic [3:0] age_ff;
   // age saturates so a long idle never looks like a fresh pin edge
   always_ff @(posedge clock_in) begin
      sk_ff <= serial_clock_in;
      cs_ff <= select_n_in;
      age_ff <= (age_ff == 4'hf) ? age_ff : age_ff + 4'h1;
      if (serial_clock_in != sk_ff || select_n_in != cs_ff) age_ff <= 4'h0;
      if (rst_in) age_ff <= 4'hf;
      armed_ff <= rst_in || (armed_ff && select_n_in);
      first_ff <= !rst_in && !select_n_in && (first_ff || armed_ff);
      woke_ff <= !rst_in && (woke_ff || analog_enable_out);
   end
   default clocking cb @(posedge clock_in);
   endclocking
   default disable iff (rst_in);
   property p_reset_state;
      disable iff (1'b0) rst_in |=> serial_out_oe_n_out && !analog_enable_out
         && analog_out_0_out == DAC_CODE_RESET && analog_out_1_out == DAC_CODE_RESET;
   endproperty
   a_reset_state: assert property (p_reset_state)
      else $error("reset state wrong");
   property p_restore;
      armed_ff && !select_n_in |-> ##[1:20] analog_enable_out;
   endproperty
   a_restore: assert property (p_restore)
      else $error("no restore after first select");
   property p_asleep;
      armed_ff |-> !analog_enable_out;
   endproperty
   a_asleep: assert property (p_asleep)
      else $error("dacs on before restore");
   property p_silent;
      first_ff |-> serial_out_oe_n_out;
   endproperty
   a_silent: assert property (p_silent)
      else $error("output driven during restore");
   property p_release;
      $rose(select_n_in) |-> ##[1:8] serial_out_oe_n_out;
   endproperty
   a_release: assert property (p_release)
      else $error("output kept after deselect");
   property p_cause;
      $fell(serial_out_oe_n_out) |-> age_ff < 4'h9;
   endproperty
   a_cause: assert property (p_cause)
      else $error("output driven without pin edge");
   property p_frozen;
      woke_ff && !analog_enable_out && $past(!analog_enable_out)
         |-> $stable(analog_out_0_out) && $stable(analog_out_1_out);
   endproperty
   a_frozen: assert property (p_frozen)
      else $error("codes moved while asleep");
   property p_wake;
      woke_ff && $rose(analog_enable_out)
         |-> $stable(analog_out_0_out) && $stable(analog_out_1_out);
   endproperty
   a_wake: assert property (p_wake)
      else $error("codes lost on wake");
   c_restore: cover property ($rose(analog_enable_out));
   c_busy: cover property (!serial_out_oe_n_out && !serial_out_out [*8]);
   c_sleep: cover property ($fell(analog_enable_out));
endmodule : port_check

bind eeprom_dac_core port_check #(.PROGRAM_CYCLES_P(PROGRAM_CYCLES_P)) chk (
   .clock_in(clock_in),
   .rst_in(rst_in),
   .select_n_in(select_n_in),
   .serial_clock_in(serial_clock_in),
   .serial_in_in(serial_in_in),
   .serial_out_out(serial_out_out),
   .serial_out_oe_n_out(serial_out_oe_n_out),
   .analog_out_0_out(analog_out_0_out),
   .analog_out_1_out(analog_out_1_out),
   .analog_enable_out(analog_enable_out)
);

// *** verif/host_model.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// host serial port, clock idles high
// ----------------------------------------
module host_model
   import eeprom_dac_pkg::*;
(
   input wire logic clock_in,
   input wire logic serial_out_in,
   input wire logic serial_out_oe_n_in,
   output logic select_n_out,
   output logic serial_clock_out,
   output logic serial_in_out
);
   // pins idle, clock stands still between frames
   initial begin
      select_n_out = 1'b1;
      serial_clock_out = 1'b1;
      serial_in_out = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(negedge clock_in);
   endtask : tick
   // first select low only starts the restore
   task automatic wake();
      tick(1);
      select_n_out = 1'b0;
      tick(40);
      select_n_out = 1'b1;
      tick(8);
   endtask : wake
   // nw words read; 0 for a plain frame, -1 cuts it after 20 bits
   task automatic frame(input logic [31:0] sh, input int nw, output logic [31:0] rd,
         output logic busy);
      int n;
      n = (nw < 0) ? 20 : (nw == 0) ? 32 : 16 + 16 * nw;
      rd = '0;
      tick(1);
      select_n_out = 1'b0;
      tick(8);
      for (int i = 0; i < n; i++) begin
         serial_clock_out = 1'b0;
         serial_in_out = (i < 32) ? sh[31 - i] : 1'($urandom());
         tick(8);
         if (i >= 16 && nw > 0) rd = {rd[30:0], serial_out_in};
         serial_clock_out = 1'b1;
         tick(8);
      end
      tick(8);
      busy = serial_out_oe_n_in === 1'b0 && serial_out_in === 1'b0 && sh[31:24] == OP_WRITE;
      for (int i = 0; i < 400 && busy && serial_out_in !== 1'b1; i++) tick(1);
      busy = busy && serial_out_in === 1'b1;
      select_n_out = 1'b1;
      serial_in_out = ~serial_in_out;
      tick(8);
   endtask : frame
endmodule : host_model

// *** verif/serial_eeprom_dac_command_port_tb_top.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// bench top
// ----------------------------------------
module serial_eeprom_dac_command_port_tb_top
   import eeprom_dac_pkg::*;
;
   logic clock_in = 1'b0;
   logic rst_in = 1'b1;
   logic select_n, sk, di, so, oe_n, en;
   logic [7:0] a0, a1;
   logic [15:0] wa, wb, wc;
   logic [31:0] exp_q[$];
   logic [31:0] act_q[$];
   int bad_count = 0;
   int total_checks = 0;
   int cycles = 0;
   event got;
   initial begin
      forever #5 clock_in = ~clock_in;
   end
   eeprom_dac_core #(.PROGRAM_CYCLES_P(50)) dut (
      .clock_in(clock_in),
      .rst_in(rst_in),
      .select_n_in(select_n),
      .serial_clock_in(sk),
      .serial_in_in(di),
      .serial_out_out(so),
      .serial_out_oe_n_out(oe_n),
      .analog_out_0_out(a0),
      .analog_out_1_out(a1),
      .analog_enable_out(en)
   );
   // undriven output line floats
   host_model host (
      .clock_in(clock_in),
      .serial_out_in(oe_n ? 1'bz : so),
      .serial_out_oe_n_in(oe_n),
      .select_n_out(select_n),
      .serial_clock_out(sk),
      .serial_in_out(di)
   );
   function automatic logic [31:0] st(input logic b, input logic e, input logic [15:0] w);
      return {7'h0, b, 7'h0, e, w};
   endfunction : st
   task automatic give_verdict();
      if (exp_q.size() != 0) bad_count++;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : give_verdict
   // note what is due, run one frame, hand over what came back
   task automatic run(input logic [7:0] op, input logic [6:0] ad, input logic [15:0] d,
         input int nw, input logic [31:0] e);
      logic [31:0] rd;
      logic busy;
      exp_q.push_back(e);
      // only documented opcodes are ever sent, never the test one
      host.frame({op, ad, 1'b0, d}, nw, rd, busy);
      act_q.push_back((op == OP_READ) ? rd : st(busy, en, {a0, a1}));
      -> got;
   endtask : run
   // power cycle; codes unknown on the very first one
   task automatic power_up(input logic [31:0] e, input logic full);
      rst_in = 1'b1;
      repeat (8) @(negedge clock_in);
      rst_in = 1'b0;
      exp_q.push_back(e);
      host.wake();
      act_q.push_back(st(1'b0, en, full ? {a0, a1} : 16'h0));
      -> got;
   endtask : power_up
   // oldest note against each result as it arrives
   initial begin
      forever begin
         @(got);
         while (act_q.size() > 0) begin
            total_checks++;
            if (exp_q.size() == 0 || act_q[0] !== exp_q[0]) begin
               bad_count++;
               $display("CHECK FAILED at %0t: got %h", $time, act_q[0]);
            end
            void'(act_q.pop_front());
            if (exp_q.size() > 0) void'(exp_q.pop_front());
         end
      end
   end
   // a hang ends the run; the whole sequence needs about 8000 clocks
   always @(posedge clock_in) begin
      cycles++;
      if (cycles == 40000) begin
         bad_count++;
         give_verdict();
      end
   end
   initial begin
      void'($urandom(32'hb6a3d48b));
      wa = 16'($urandom());
      wb = 16'($urandom());
      wc = ~wb;
      power_up(st(1'b0, 1'b1, 16'h0), 1'b0);
      run(OP_WRITE, 7'h00, wa, 0, st(1'b0, 1'b1, wa));
      run(OP_UNLOCK, 7'h55, wb, 0, st(1'b0, 1'b1, wa));
      run(OP_WRITE, 7'h00, wb, 0, st(1'b1, 1'b1, wb));
      run(OP_WRITE, 7'h7f, wc, 0, st(1'b1, 1'b1, wb));
      run(OP_LOCK, 7'h2a, wa, 0, st(1'b0, 1'b1, wb));
      run(OP_WRITE, 7'h7f, wa, 0, st(1'b0, 1'b1, wb));
      run(OP_READ, 7'h7f, wa, 2, {wc, wb});
      $display("test write and read done");
      run(OP_RECALL, 7'h7f, wa, 0, st(1'b0, 1'b1, wc));
      run(OP_RECALL, 7'h00, wa, -1, st(1'b0, 1'b1, wc));
      run(OP_SLEEP_ENTER, 7'h11, wa, 0, st(1'b0, 1'b0, wc));
      run(OP_RECALL, 7'h00, wa, 0, st(1'b0, 1'b0, wc));
      run(OP_SLEEP_EXIT, 7'h33, wa, 0, st(1'b0, 1'b1, wc));
      $display("test recall and sleep done");
      power_up(st(1'b0, 1'b1, wb), 1'b1);
      run(OP_READ, 7'h00, wa, 1, {16'h0, wb});
      run(OP_WRITE, 7'h00, wc, 0, st(1'b0, 1'b1, wc));
      $display("test power cycle done");
      // let the compare process take the last result first
      @(negedge clock_in);
      give_verdict();
   end
endmodule : serial_eeprom_dac_command_port_tb_top
